// *** src/arp_regs.vh ***
`ifndef ARP_REGS_VH
`define ARP_REGS_VH

// register indices; byte address is four times the index
`define ARP_IDX_S1_LO      32'hFFFFF302
`define ARP_IDX_S1_HI      32'hFFFFF303
`define ARP_IDX_S2_LO      32'hFFFFF304
`define ARP_IDX_S2_HI      32'hFFFFF305
`define ARP_IDX_S3_LO      32'hFFFFF306
`define ARP_IDX_S3_HI      32'hFFFFF307
`define ARP_IDX_S4_LO      32'hFFFFF308
`define ARP_IDX_S4_HI      32'hFFFFF309
`define ARP_IDX_IRQ_STAT   32'hFFFFF340
`define ARP_IDX_IRQ_MASK   32'hFFFFF341

// slot geometry
`define ARP_SLOTS          4
`define ARP_SLOT_W         2
`define ARP_RES_W          10
`define ARP_IDX_STRIDE     32'h00000002

// lower byte layout
`define ARP_LO_RES_MSB     7
`define ARP_LO_RES_LSB     6
`define ARP_LO_FILL        4'hF
`define ARP_LO_OVR_BIT     1
`define ARP_LO_STORED_BIT  0

// upper byte carries result bits 9..2
`define ARP_HI_RES_MSB     9
`define ARP_HI_RES_LSB     2

// interrupt status / mask layout
`define ARP_STAT_W         8
`define ARP_STAT_STORED_LSB 0
`define ARP_STAT_OVR_LSB   4
`define ARP_STAT_RESET     8'h00
`define ARP_MASK_RESET     8'h00
`define ARP_RES_RESET      10'h000
`define ARP_DATA_ZERO      32'h00000000

`endif

// *** src/arp_slot.v ***
`timescale 1ns/1ns
`include "arp_regs.vh"

module arp_slot
(
   // clock and reset
   input  wire                    clk,
   input  wire                    rst_sync_b,
   // sequencer side
   input  wire                    store,
   input  wire [`ARP_RES_W-1:0]   result_in,
   // processor side
   input  wire                    rd_clear,
   // state
   output reg  [`ARP_RES_W-1:0]   result_q,
   output reg                     stored,
   output reg                     overrun,
   output wire                    overrun_evt
);

   wire next_stored;
   wire next_overrun;

   // new value lands while previous one is still unread
   assign overrun_evt  = store & stored;                          // [RULE_10]
   // set wins over the read clear so a result arriving with the read stays flagged
   assign next_stored  = store | (stored & ~rd_clear);            // [RULE_05] [RULE_06]
   assign next_overrun = overrun_evt | (overrun & ~rd_clear);     // [RULE_04] [RULE_10]

   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         result_q <= `ARP_RES_RESET;
         stored   <= 1'b0;
         overrun  <= 1'b0;
      end
      else
      begin
         if (store)
         begin
            result_q <= result_in;                                // [RULE_01] [RULE_02]
         end
         stored  <= next_stored;
         overrun <= next_overrun;
      end
   end

endmodule // arp_slot

// *** src/arp_result_regs.v ***
// What this block does
// RULE_01 - upper byte returns result bits 9..2; content undefined before first store
// RULE_02 - lower byte bits 7,6 return result bits 1,0; undefined after reset
// RULE_03 - lower byte bits 5..2 always read as ones
// RULE_04 - lower byte bit 1 is the overrun flag, zero after reset
// RULE_05 - lower byte bit 0 is stored flag, set by each new result
// RULE_06 - reading the lower byte clears stored flag; upper read leaves it
// RULE_07 - same flag layout in every slot, stored flag at bit 0
// RULE_08 - slot 1 low then high, slot 2 follows in same order
// RULE_09 - slots 3 and 4 continue the same consecutive low-then-high layout
// RULE_10 - overrun set when storing over unread result; cleared by lower read
// RULE_11 - result registers are read-only; writes change nothing
`timescale 1ns/1ns
`include "arp_regs.vh"

module arp_result_regs
#(
   parameter ADDR_W = 12
)
(
   // clock and reset
   input  wire                    clk,
   input  wire                    rst_b,
   // apb slave
   input  wire                    psel,
   input  wire                    penable,
   input  wire                    pwrite,
   input  wire [ADDR_W-1:0]       paddr,
   input  wire [31:0]             pwdata,
   input  wire [3:0]              pstrb,
   output reg  [31:0]             prdata,
   output wire                    pready,
   output wire                    pslverr,
   // conversion sequencer
   input  wire                    conv_store,
   input  wire [`ARP_SLOT_W-1:0]  conv_slot,
   input  wire [`ARP_RES_W-1:0]   conv_result,
   // interrupt
   output wire                    irq
);

   localparam IW = ADDR_W - 2;

   // reset release
   reg                            rst_meta_b;
   reg                            rst_sync_b;

   // bus phase
   wire                           setup_ph;
   wire                           access_ph;
   wire [IW-1:0]                  word_idx;

   // decode
   reg  [`ARP_SLOTS-1:0]          hit_low;
   reg  [`ARP_SLOTS-1:0]          hit_high;
   reg                            hit_stat;
   reg                            hit_mask;
   reg                            mapped;
   reg  [31:0]                    next_rdata;
   reg                            err_q;

   // slots
   wire [`ARP_SLOTS-1:0]          slot_store;
   wire [`ARP_SLOTS-1:0]          slot_rd_clear;
   wire [`ARP_SLOTS-1:0]          slot_stored;
   wire [`ARP_SLOTS-1:0]          slot_overrun;
   wire [`ARP_SLOTS-1:0]          slot_ovr_evt;
   wire [`ARP_SLOTS*`ARP_RES_W-1:0] slot_result;

   // interrupt state
   reg  [`ARP_STAT_W-1:0]         irq_status;
   reg  [`ARP_STAT_W-1:0]         irq_mask;
   wire [`ARP_STAT_W-1:0]         stat_set;
   wire [`ARP_STAT_W-1:0]         stat_clr;
   wire [`ARP_STAT_W-1:0]         next_status;
   wire                           wr_stat;
   wire                           wr_mask;

   integer                        k;

   // true when the word index matches a printed register index
   function idx_is;
      input [IW-1:0] a;
      input [31:0]   i;
      begin
         idx_is = (a == i[IW-1:0]);
      end
   endfunction

   // lower byte image, shared by all slots
   function [7:0] low_byte;
      input [`ARP_RES_W-1:0] res;
      input                  ovr;
      input                  stored;
      begin
         low_byte = {res[1:0], `ARP_LO_FILL, ovr, stored};   // [RULE_02] [RULE_03] [RULE_07]
      end
   endfunction

   // upper byte image
   function [7:0] high_byte;
      input [`ARP_RES_W-1:0] res;
      begin
         high_byte = res[`ARP_HI_RES_MSB:`ARP_HI_RES_LSB];     // [RULE_01]
      end
   endfunction

   // two-flop reset release; assertion stays asynchronous
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign word_idx  = paddr[ADDR_W-1:2];

   // zero wait state: data and error were settled during setup
   assign pready  = access_ph;
   assign pslverr = access_ph & err_q;

   // address decode and read image
   always @*
   begin
      hit_low    = {`ARP_SLOTS{1'b0}};
      hit_high   = {`ARP_SLOTS{1'b0}};
      hit_stat   = idx_is(word_idx, `ARP_IDX_IRQ_STAT);
      hit_mask   = idx_is(word_idx, `ARP_IDX_IRQ_MASK);
      next_rdata = `ARP_DATA_ZERO;
      for (k = 0; k < `ARP_SLOTS; k = k + 1)
      begin
         // consecutive pairs, low byte first        [RULE_08] [RULE_09]
         hit_low[k]  = idx_is(word_idx, `ARP_IDX_S1_LO + `ARP_IDX_STRIDE * k);
         hit_high[k] = idx_is(word_idx, `ARP_IDX_S1_HI + `ARP_IDX_STRIDE * k);
      end
      mapped = (|hit_low) | (|hit_high) | hit_stat | hit_mask;
      for (k = 0; k < `ARP_SLOTS; k = k + 1)
      begin
         if (hit_low[k])
         begin
            next_rdata[7:0] = low_byte(slot_result[k*`ARP_RES_W +: `ARP_RES_W],
                                       slot_overrun[k], slot_stored[k]);
         end
         if (hit_high[k])
         begin
            next_rdata[7:0] = high_byte(slot_result[k*`ARP_RES_W +: `ARP_RES_W]);
         end
      end
      if (hit_stat)
      begin
         next_rdata[`ARP_STAT_W-1:0] = irq_status;
      end
      if (hit_mask)
      begin
         next_rdata[`ARP_STAT_W-1:0] = irq_mask;
      end
   end

   // read data captured at end of setup, so the flags seen match the clear
   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         prdata <= `ARP_DATA_ZERO;
         err_q  <= 1'b0;
      end
      else if (setup_ph)
      begin
         err_q <= ~mapped;
         if (!pwrite)
         begin
            prdata <= next_rdata;
         end
         else
         begin
            prdata <= `ARP_DATA_ZERO;
         end
      end
   end

   // per-slot strobes; writes never reach the slots           [RULE_11]
   genvar g;
   generate
      for (g = 0; g < `ARP_SLOTS; g = g + 1)
      begin : slot_gen
         // slot number sized to the select lines, so the compare has equal widths
         localparam [`ARP_SLOT_W-1:0] SLOT_ID = g;

         assign slot_store[g]    = conv_store & (conv_slot == SLOT_ID);
         // only the lower byte read clears; upper read is side-effect free
         assign slot_rd_clear[g] = setup_ph & ~pwrite & hit_low[g];   // [RULE_06] [RULE_10]

         arp_slot arp_slot_inst
         (
            .clk         (clk),
            .rst_sync_b  (rst_sync_b),
            .store       (slot_store[g]),
            .result_in   (conv_result),
            .rd_clear    (slot_rd_clear[g]),
            .result_q    (slot_result[g*`ARP_RES_W +: `ARP_RES_W]),
            .stored      (slot_stored[g]),
            .overrun     (slot_overrun[g]),
            .overrun_evt (slot_ovr_evt[g])
         );
      end
   endgenerate

   // interrupt: sticky status, write one to clear, set wins
   assign wr_stat  = access_ph & pwrite & hit_stat & pstrb[0];
   assign wr_mask  = access_ph & pwrite & hit_mask & pstrb[0];
   assign stat_set = {slot_ovr_evt, slot_store};
   assign stat_clr = wr_stat ? pwdata[`ARP_STAT_W-1:0] : {`ARP_STAT_W{1'b0}};
   assign next_status = stat_set | (irq_status & ~stat_clr);

   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         irq_status <= `ARP_STAT_RESET;
         irq_mask   <= `ARP_MASK_RESET;
      end
      else
      begin
         irq_status <= next_status;
         if (wr_mask)
         begin
            irq_mask <= pwdata[`ARP_STAT_W-1:0];
         end
      end
   end

   assign irq = |(irq_status & irq_mask);

endmodule // arp_result_regs

// *** testbench/arp_seq_model.sv ***
`timescale 1ns/1ns
// sequencer side: one store pulse per request, lines scrambled when idle
module arp_seq_model
(
   input  wire       clk,
   input  wire       go,
   input  wire [1:0] s,
   input  wire [9:0] v,
   output reg        conv_store = 1'b0,
   output reg  [1:0] conv_slot = 2'h0,
   output reg  [9:0] conv_result = 10'h000
);
   always @(posedge clk)
   begin
      conv_store <= go;
      conv_slot <= go ? s : ~conv_slot;
      conv_result <= go ? v : ~conv_result;
   end
endmodule // arp_seq_model

// *** testbench/arp_result_regs_checker.sv ***
`timescale 1ns/1ns
module arp_checker
#(
   parameter ADDR_W = 12
)
(
   input wire              clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, conv_store,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0]       pwdata, prdata,
   input wire [3:0]        pstrb,
   input wire [1:0]        conv_slot,
   input wire [9:0]        conv_result
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire       rd = psel && !penable && !pwrite;
   wire       rs_map = paddr[11:2] >= 10'h302 && paddr[11:2] <= 10'h309;
   wire [1:0] rs = paddr[4:3] - 2'h1;
   wire       lo = rd && rs_map && !paddr[2];
   wire       hi = rd && rs_map && paddr[2];
   wire       mapped = rs_map || paddr[11:2] == 10'h340 || paddr[11:2] == 10'h341;
   property p_hi;
      conv_store ##1 (hi && rs == $past(conv_slot)) |=> prdata[7:0] == $past(conv_result[9:2], 2);
   endproperty
   a_hi: assert property (p_hi) else $error("upper byte wrong");
   property p_lo;
      conv_store ##1 (lo && rs == $past(conv_slot))
         |=> prdata[7:6] == $past(conv_result[1:0], 2) && prdata[0];
   endproperty
   a_lo: assert property (p_lo) else $error("lower byte wrong");
   property p_fill;
      lo |=> prdata[5:2] == 4'hF;
   endproperty
   a_fill: assert property (p_fill) else $error("unused bits not ones");
   property p_ovr;
      conv_store ##2 (conv_store && conv_slot == $past(conv_slot, 2)) ##1
         (lo && rs == $past(conv_slot)) |=> prdata[1:0] == 2'h3;
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun not flagged");
   property p_clr;
      (lo && !conv_store) ##1 !conv_store [*2] ##1 (lo && paddr == $past(paddr, 3))
         |=> prdata[1:0] == 2'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("flags not cleared");
   property p_keep;
      conv_store ##1 (hi && rs == $past(conv_slot)) ##3 (lo && rs == $past(rs, 3)) |=> prdata[0];
   endproperty
   a_keep: assert property (p_keep) else $error("upper read cleared flag");
   property p_map;
      psel && penable |-> pslverr == !mapped;
   endproperty
   a_map: assert property (p_map) else $error("address decode wrong");
   property p_irq;
      psel && penable && pwrite && paddr[11:2] == 10'h341 && pstrb[0] && pwdata[7:0] == 8'h00
         |=> !irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq with mask clear");
endmodule // arp_checker
bind arp_result_regs arp_checker #(.ADDR_W(ADDR_W)) arp_checker_inst(.clk(clk), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .irq(irq),
   .conv_store(conv_store), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb),
   .conv_slot(conv_slot), .conv_result(conv_result));

// *** testbench/arp_result_regs_tb.sv ***
`timescale 1ns/1ns
module arp_result_regs_tb;
   reg clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, go = 0, e;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, q;
   reg [3:0] pstrb = 4'hF;
   reg [1:0] gs = 0;
   reg [9:0] gv = 0, v;
   wire [31:0] prdata;
   wire pready, pslverr, conv_store, irq;
   wire [1:0] conv_slot;
   wire [9:0] conv_result;
   integer err_count = 0, checks = 0, k;
   initial forever #25 clk = ~clk;
   arp_result_regs arp_result_regs_inst(.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_store(conv_store), .conv_slot(conv_slot),
      .conv_result(conv_result), .irq(irq));
   arp_seq_model arp_seq_model_inst(.clk(clk), .go(go), .s(gs), .v(gv), .conv_store(conv_store),
      .conv_slot(conv_slot), .conv_result(conv_result));
   task chk(input [31:0] g, input [31:0] x);
   begin
      checks = checks + 1;
      if (g !== x)
      begin
         err_count = err_count + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
   begin
      @(posedge clk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata; e = pslverr;
      psel <= 0; penable <= 0;
   end
   endtask
   task st(input [1:0] s, input [9:0] x);
   begin
      @(posedge clk);
      go <= 1; gs <= s; gv <= x;
      @(posedge clk);
      go <= 0;
   end
   endtask
   function [11:0] la(input [1:0] s);
      la = 12'hC08 + {7'h00, s, 3'h0};
   endfunction
   task end_of_test;
   begin
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   end
   endtask
   task t_slots;
   begin
      apb(0, la(0), 0); chk(q, 32'h3C);
      for (k = 0; k < 4; k = k + 1)
      begin
         v = {k[1:0], 6'h25, ~k[1:0]};
         st(k[1:0], v);
         apb(0, la(k[1:0]) + 12'h4, 0); chk(q, {24'h0, v[9:2]});
         apb(0, la(k[1:0]), 0); chk(q, {24'h0, v[1:0], 6'h3D});
         apb(0, la(k[1:0]), 0); chk(q, {24'h0, v[1:0], 6'h3C});
      end
      $display("t_slots done");
   end
   endtask
   task t_ovr;
   begin
      st(2, 10'h3C1); st(2, 10'h2C2);
      apb(0, la(2), 0); chk(q, 32'hBF);
      apb(0, la(2) + 12'h4, 0); chk(q, 32'hB0);
      apb(0, la(2), 0); chk(q, 32'hBC);
      $display("t_ovr done");
   end
   endtask
   task t_wr;
   begin
      st(0, 10'h0F3);
      apb(1, la(0), 0); chk(e, 0);
      apb(1, la(0) + 12'h4, 0);
      apb(0, la(0) + 12'h4, 0); chk(q, 32'h3C);
      apb(0, la(0), 0); chk(q, 32'hFD);
      apb(0, 12'hFF0, 0); chk(q, 0); chk(e, 1);
      $display("t_wr done");
   end
   endtask
   task t_irq;
   begin
      apb(1, 12'hD00, 32'hFF); apb(1, 12'hD04, 1); chk(irq, 0);
      st(0, 10'h001); repeat (2) @(posedge clk); chk(irq, 1);
      apb(0, 12'hD00, 0); chk(q, 1);
      apb(1, 12'hD00, 1); @(posedge clk); chk(irq, 0);
      st(0, 10'h002); apb(1, 12'hD04, 0); @(posedge clk); chk(irq, 0);
      $display("t_irq done");
   end
   endtask
   initial
   begin
      #100000;
      err_count = err_count + 1;
      end_of_test;
   end
   initial
   begin
      repeat (6) @(posedge clk);
      rst_b <= 1;
      repeat (3) @(posedge clk);
      t_slots; t_ovr; t_wr; t_irq;
      end_of_test;
   end
endmodule // arp_result_regs_tb
